//--- design/serial_dac_input_interface.v
// Functional notes
// - Frame select falling starts a word; one bit sampled per rising serial clock.
// - Words are 16 bits, most significant bit first.
// - Frame select rising after 16 bits copies shift register to DAC register if load strobe is low.
// - Serial clock and data ignored while frame select high.
// - Load strobe falling after frame select rise updates DAC register.
// - Load strobe held low: update at frame select rising edge.
// - Reset forces DAC register to zero code.
// - Top four bits decoded into 15 segment switch controls.
// - Low 12 bits drive ladder switches directly.
// - Code is straight unsigned binary in unipolar use.
// - Bipolar use treats code as offset binary, 8000h is zero.
// - Shift register is not cleared at reset.
// - Extra bits keep the last 16; short words keep old bits.
`timescale 1ns/100ps
`include "serial_dac_defines.vh"
module serial_dac_input_interface (
   input  wire                        core_clk,
   input  wire                        sys_rst,
   input  wire                        clk_en,
   input  wire                        frame_sel_n,
   input  wire                        serial_clk,
   input  wire                        serial_din,
   input  wire                        dac_load_strobe_n,
   output reg  [`WORD_BITS-1:0]       dac_code,
   output reg  [`SEG_COUNT-1:0]       segment_switch,
   output reg  [`LADDER_BITS-1:0]     ladder_switch,
   output reg                         word_overrun,
   output reg                         bipolar_negative
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Serial clock at 1.25 MHz in use; 10 MHz core only resolves slow links.
   // Reset values match the idle level of each pin but a held-low load strobe, which then sees one false fall after reset.
   reg [2:0] cs_sync;
   reg [2:0] sck_sync;
   reg [2:0] din_sync;
   reg [2:0] ld_sync;
   reg       cs_state;
   reg       sck_state;
   reg       ld_state;

   always @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         cs_sync   <= 3'h7;
         sck_sync  <= 3'h0;
         din_sync  <= 3'h0;
         ld_sync   <= 3'h7;
         cs_state  <= 1'b1;
         sck_state <= 1'b0;
         ld_state  <= 1'b1;
      end
      else if (clk_en)
      begin
         cs_sync  <= {cs_sync[1:0], frame_sel_n};
         sck_sync <= {sck_sync[1:0], serial_clk};
         din_sync <= {din_sync[1:0], serial_din};
         ld_sync  <= {ld_sync[1:0], dac_load_strobe_n};
         if (cs_sync[1] == cs_sync[2])
            cs_state <= cs_sync[2];
         if (sck_sync[1] == sck_sync[2])
            sck_state <= sck_sync[2];
         if (ld_sync[1] == ld_sync[2])
            ld_state <= ld_sync[2];
      end
   end


   // ----------------------------------------
   // Edge detection on the filtered pins
   // ----------------------------------------
   wire cs_agree;
   wire sck_agree;
   wire ld_agree;
   wire cs_fall;
   wire cs_rise;
   wire sck_rise;
   wire ld_fall;

   // An edge counts only once the last two stages agree, so a glitch is dropped
   assign cs_agree  = (cs_sync[1] == cs_sync[2]);
   assign sck_agree = (sck_sync[1] == sck_sync[2]);
   assign ld_agree  = (ld_sync[1] == ld_sync[2]);
   assign cs_fall   = cs_state & cs_agree & ~cs_sync[2];
   assign cs_rise   = ~cs_state & cs_agree & cs_sync[2];
   assign sck_rise  = ~sck_state & sck_agree & sck_sync[2];
   assign ld_fall   = ld_state & ld_agree & ~ld_sync[2];

   // ----------------------------------------
   // Input shift register
   // ----------------------------------------
   // No reset on the shift register: contents stay undefined until loaded.
   reg [`WORD_BITS-1:0] shift_reg;
   reg [4:0]            bit_count;
   reg                  word_ready;

   always @(posedge core_clk)
   begin
      if (clk_en & ~cs_state & sck_rise)
         shift_reg <= {shift_reg[`WORD_BITS-2:0], din_sync[2]};
   end

   always @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         bit_count    <= 5'h00;
         word_overrun <= 1'b0;
      end
      else if (clk_en)
      begin
         if (cs_fall)
         begin
            bit_count    <= 5'h00;
            word_overrun <= 1'b0;
         end
         else if (~cs_state & sck_rise)
         begin
            if (bit_count == 5'h10)
               word_overrun <= 1'b1;
            else
               bit_count <= bit_count + 5'h01;
         end
      end
   end

   // ----------------------------------------
   // Word held for a strobed update
   // ----------------------------------------
   // A strobe fall with no complete word behind it must not load stale bits.
   always @(posedge core_clk)
   begin
      if (sys_rst)
         word_ready <= 1'b0;
      else if (clk_en)
      begin
         if (cs_rise)
            word_ready <= (bit_count == 5'h10);
         else if (ld_fall)
            word_ready <= 1'b0;
      end
   end

   // ----------------------------------------
   // Word buffer between link and DAC register
   // ----------------------------------------
   wire                  fifo_in_ready;
   wire                  fifo_out_valid;
   wire [`WORD_BITS-1:0] fifo_out_data;
   wire                  sync_load;
   wire                  strobe_load;
   wire                  fifo_push;
   wire                  load_request;
   wire                  fifo_out_ready;

   // Frame end with strobe low loads at once; strobe high waits for a strobe fall.
   assign sync_load   = cs_rise & (bit_count == 5'h10) & ~ld_state;
   assign strobe_load = ld_fall & cs_state & word_ready;
   assign load_request   = sync_load | strobe_load;
   // The DAC register drains a word every enabled cycle, so the buffer never fills.
   assign fifo_out_ready = 1'b1;
   assign fifo_push      = load_request & fifo_in_ready;

   word_fifo #(
      .WIDTH (`WORD_BITS),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_AW)
   ) u_fifo (
      .core_clk  (core_clk),
      .sys_rst   (sys_rst),
      .clk_en    (clk_en),
      .in_valid  (fifo_push),
      .in_ready  (fifo_in_ready),
      .in_data   (shift_reg),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   // ----------------------------------------
   // DAC register and switch decode
   // ----------------------------------------
   reg [`SEG_COUNT-1:0]   next_segment;
   reg [`WORD_BITS-1:0]   next_dac_code;
   reg [`LADDER_BITS-1:0] next_ladder;
   reg                    next_negative;
   integer                i;

   // Straight binary for the register; offset binary only matters to the sign flag
   always @*
   begin
      next_dac_code = fifo_out_data;
      next_ladder   = fifo_out_data[`LADDER_BITS-1:0];
      next_negative = (fifo_out_data < `BIPOLAR_ZERO);
   end

   // ----------------------------------------
   // Segment thermometer decode
   // ----------------------------------------
   always @*
   begin
      next_segment = {`SEG_COUNT{1'b0}};
      for (i = 0; i < `SEG_COUNT; i = i + 1)
         next_segment[i] = (fifo_out_data[`WORD_BITS-1:`SEG_LSB] > i);
   end

   always @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         dac_code         <= `DAC_RESET_CODE;
         segment_switch   <= {`SEG_COUNT{1'b0}};
         ladder_switch    <= {`LADDER_BITS{1'b0}};
         bipolar_negative <= 1'b1;
      end
      else if (clk_en & fifo_out_valid)
      begin
         // Clock enable low freezes every register here.
         dac_code         <= next_dac_code;
         segment_switch   <= next_segment;
         ladder_switch    <= next_ladder;
         bipolar_negative <= next_negative;
      end
   end
endmodule

//--- design/word_fifo.v
`timescale 1ns/100ps
// ----------------------------------------
// Small synchronous FIFO
// ----------------------------------------
module word_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 8,
   parameter AW    = 3
)(
   input  wire             core_clk,
   input  wire             sys_rst,
   input  wire             clk_en,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      count;
   wire            push;
   wire            pop;

   assign in_ready  = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end
      else if (clk_en)
      begin
         if (push)
         begin
            mem[wr_ptr] <= in_data;
            wr_ptr      <= wr_ptr + 1'b1;
         end
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         if (push & ~pop)
            count <= count + 1'b1;
         else if (pop & ~push)
            count <= count - 1'b1;
      end
   end
endmodule

//--- shared/serial_dac_defines.vh
`ifndef SERIAL_DAC_DEFINES_VH
`define SERIAL_DAC_DEFINES_VH
// ----------------------------------------
// Word format
// ----------------------------------------
`define WORD_BITS        16
`define SEG_BITS         4
`define SEG_LSB          12
`define SEG_COUNT        15
`define LADDER_BITS      12
`define DAC_RESET_CODE   16'h0000
`define BIPOLAR_ZERO     16'h8000
// ----------------------------------------
// Buffer and timing
// ----------------------------------------
`define FIFO_DEPTH       8
`define FIFO_AW          3
`define SCLK_MAX_MHZ     25
`define CORE_CLK_MHZ     10
`endif

//--- test/serial_dac_checker_assertions.sv
`timescale 1ns/100ps
module serial_dac_checker (
   input logic        core_clk,
   input logic        sys_rst,
   input logic        frame_sel_n,
   input logic        serial_clk,
   input logic        serial_din,
   input logic        dac_load_strobe_n,
   input logic [15:0] dac_code,
   input logic [14:0] segment_switch,
   input logic [11:0] ladder_switch,
   input logic        word_overrun,
   input logic        bipolar_negative
);
   logic [4:0]  bits;
   logic [15:0] shadow;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // Pins sampled raw; the bit period is long against the synchroniser
   always_ff @(posedge core_clk)
   begin
      if ($fell(frame_sel_n))
         bits <= 5'h00;
      else if (!frame_sel_n && $rose(serial_clk) && bits != 5'h1F)
         bits <= bits + 5'h01;
      if (!frame_sel_n && $rose(serial_clk))
         shadow <= {shadow[14:0], serial_din};
   end
   a_reset_clears: assert property (disable iff (1'b0) sys_rst |=> dac_code == 16'h0000)
      else $error("reset left code");
   a_frame_load: assert property ($rose(frame_sel_n) && !dac_load_strobe_n && bits >= 5'h10
      |-> ##10 dac_code == shadow) else $error("frame end load wrong");
   a_strobe_load: assert property ($fell(dac_load_strobe_n) && frame_sel_n && bits == 5'h10
      |-> ##10 dac_code == shadow) else $error("strobe load wrong");
   a_no_early_load: assert property ($rose(frame_sel_n) && (dac_load_strobe_n || bits < 5'h10)
      |-> $stable(dac_code) [*8]) else $error("load not allowed");
   a_idle_hold: assert property ((frame_sel_n && $stable(dac_load_strobe_n)) [*8]
      |-> ##3 $stable(dac_code)) else $error("idle code change");
   a_frame_hold: assert property ((!frame_sel_n) [*6] |=> $stable(dac_code))
      else $error("code change in frame");
   a_overrun_flag: assert property ($rose(frame_sel_n) |-> ##10 word_overrun == (bits > 5'h10))
      else $error("overrun flag wrong");
   a_ladder_copy: assert property ($stable(dac_code) [*2] |-> ladder_switch == dac_code[11:0])
      else $error("ladder wrong");
   a_segment_therm: assert property ($stable(dac_code) [*2]
      |-> segment_switch == 15'((16'h0001 << dac_code[15:12]) - 16'h0001)) else $error("segments");
   a_sign_flag: assert property ($stable(dac_code) [*2] |-> bipolar_negative == !dac_code[15])
      else $error("sign flag wrong");
   c_frame: cover property ($rose(frame_sel_n) && bits == 5'h10);
   c_strobe: cover property ($fell(dac_load_strobe_n) && frame_sel_n);
   c_overrun: cover property ($rose(word_overrun));
endmodule
bind serial_dac_input_interface serial_dac_checker chk (.core_clk(core_clk), .sys_rst(sys_rst),
   .frame_sel_n(frame_sel_n), .serial_clk(serial_clk), .serial_din(serial_din),
   .dac_load_strobe_n(dac_load_strobe_n), .dac_code(dac_code), .ladder_switch(ladder_switch),
   .segment_switch(segment_switch), .word_overrun(word_overrun), .bipolar_negative(bipolar_negative));

//--- test/serial_dac_input_interface_tb.sv
`timescale 1ns/100ps
module serial_dac_input_interface_tb;
   logic        core_clk = 1'b0;
   logic        sys_rst = 1'b1;
   wire         frame_sel_n, serial_clk, serial_din, dac_load_strobe_n;
   wire  [15:0] dac_code;
   wire  [14:0] segment_switch;
   wire  [11:0] ladder_switch;
   wire         word_overrun, bipolar_negative;
   int          miscompares = 0;
   int          checks_done = 0;
   int          seed = 91785;
   logic [15:0] expect_code = 16'h0000;
   always #50 core_clk = ~core_clk;
   serial_host host (.core_clk(core_clk), .frame_sel_n(frame_sel_n), .serial_clk(serial_clk),
      .serial_din(serial_din), .dac_load_strobe_n(dac_load_strobe_n));
   serial_dac_input_interface dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1),
      .frame_sel_n(frame_sel_n), .serial_clk(serial_clk), .serial_din(serial_din),
      .dac_load_strobe_n(dac_load_strobe_n), .dac_code(dac_code), .segment_switch(segment_switch),
      .ladder_switch(ladder_switch), .word_overrun(word_overrun), .bipolar_negative(bipolar_negative));
   task check(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want)
      begin
         miscompares++;
         $display("mismatch at %0t: seen %h want %h", $time, seen, want);
      end
   endtask
   function logic [14:0] therm(input logic [3:0] top);
      return 15'((16'h0001 << top) - 16'h0001);
   endfunction
   task wrap_up;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Short frames are dropped, long ones keep their last 16 bits
   task frame(input logic [31:0] word, input int nbits, input logic strobed);
      host.send(word, nbits, strobed);
      if (nbits >= 16)
         expect_code = word[15:0];
      check(dac_code, expect_code);
      check(segment_switch, therm(expect_code[15:12]));
      check(ladder_switch, expect_code[11:0]);
      check(bipolar_negative, expect_code < 16'h8000);
      check(word_overrun, nbits > 16);
   endtask
   initial
   begin
      repeat (6) @(negedge core_clk);
      sys_rst = 1'b0;
      check(dac_code, 16'h0000);
      frame(32'h00008000, 16, 1'b0);
      frame(32'h0000FFFF, 16, 1'b1);
      frame(32'h000ABCDE, 20, 1'b0);
      frame(32'h00000003, 4, 1'b0);
      frame(32'h00000001, 16, 1'b1);
      for (int i = 0; i < 16; i++)
         frame({16'h0000, 4'(i), 12'($random(seed))}, 16, 1'(i % 3 == 0));
      wrap_up;
   end
endmodule

//--- test/serial_host.sv
`timescale 1ns/100ps
module serial_host (
   input  logic core_clk,
   output logic frame_sel_n,
   output logic serial_clk,
   output logic serial_din,
   output logic dac_load_strobe_n
);
   initial
   begin
      frame_sel_n = 1'b1;
      serial_clk = 1'b0;
      serial_din = 1'b0;
      dac_load_strobe_n = 1'b0;
   end
   // Serial clock stands low between frames
   task automatic send(input logic [31:0] word, input int nbits, input logic strobed);
      dac_load_strobe_n = strobed;
      frame_sel_n = 1'b0;
      repeat (4) @(negedge core_clk);
      for (int i = nbits - 1; i >= 0; i--)
      begin
         serial_din = word[i];
         repeat (4) @(negedge core_clk);
         serial_clk = 1'b1;
         repeat (4) @(negedge core_clk);
         serial_clk = 1'b0;
      end
      repeat (4) @(negedge core_clk);
      frame_sel_n = 1'b1;
      serial_din = ~serial_din; // Released line must not keep its last bit
      repeat (12) @(negedge core_clk);
      if (strobed)
      begin
         dac_load_strobe_n = 1'b0;
         repeat (12) @(negedge core_clk);
      end
   endtask
endmodule
